// >>> hdl/dpda_cfg.svh
// constants for the dot-product accumulate datapath
`ifndef DPDA_CFG_SVH
`define DPDA_CFG_SVH
`define DPDA_ACC_NUM 4
`define DPDA_FLAG_LSB 16
`define DPDA_FLAG_MSB 19
`define DPDA_Q15_MINUS_ONE 16'h8000
`define DPDA_Q31_MAX 32'h7FFFFFFF
`define DPDA_Q31_MIN 32'h80000000
`define DPDA_WORD_ZERO 32'h00000000
`define DPDA_WORD_ONES 32'hFFFFFFFF
`define DPDA_CTRL_RESET 32'h00000000
`define DPDA_HALF_HI_MSB 31
`define DPDA_HALF_HI_LSB 16
`define DPDA_HALF_LO_MSB 15
`define DPDA_HALF_LO_LSB 0
`define DPDA_BYTE_TOP_MSB 31
`define DPDA_BYTE_TOP_LSB 24
`define DPDA_BYTE_NEXT_MSB 23
`define DPDA_BYTE_NEXT_LSB 16
`define DPDA_CHK_MSB 62
`define DPDA_CHK_LSB 31
`endif

// >>> hdl/dpda_pkg.sv
// types for the dot-product accumulate datapath
`default_nettype none
package dpda_pkg;
  typedef enum logic [2:0] {
    DPDA_OP_CROSS_FRAC = 3'b001,
    DPDA_OP_CROSS_FRAC_SAT = 3'b010,
    DPDA_OP_UBYTE_UPPER = 3'b100
  } dpda_op_t;
  typedef logic [1:0] dpda_acc_sel_t;
endpackage
`default_nettype wire

// >>> hdl/dpda_datapath.sv
// dot-product accumulate datapath with four 64-bit accumulators
`timescale 1ns/1ps
`default_nettype none
`include "dpda_cfg.svh"
// Function
// - cross ops multiply a.hi*b.lo and a.lo*b.hi, each shifted left one bit
// - minus one times minus one gives Q31 max and sets the overflow flag
// - both Q31 products sign-extend to 64 bits, summed, added to accumulator
// - non-saturating cross op writes full 64-bit sum unclamped
// - two-bit selector picks one of four accumulators; zero is the original pair
// - overflow flag sits at control bit 16 plus selector; others untouched
// - saturating: non-negative sum with bits 62..31 not zero clamps to Q31 max
// - saturating: negative sum with bits 62..31 not all ones clamps to Q31 min
// - saturating op flags on multiply or accumulate saturation
// - byte op multiplies upper two unsigned byte pairs into 16-bit products
// - byte op zero-extends products and adds to accumulator, no saturation
// - byte op never touches overflow flags
// - no operand-dependent exceptions are raised
module dpda_datapath (
  input wire logic mclk_i,
  input wire logic rstn_i,
  input wire logic op_valid_i,
  input wire dpda_pkg::dpda_op_t op_i,
  input wire dpda_pkg::dpda_acc_sel_t accumulator_select_i,
  input wire logic [31:0] source_reg_a_i,
  input wire logic [31:0] source_reg_b_i,
  input wire dpda_pkg::dpda_acc_sel_t read_select_i,
  output logic [31:0] acc_high_word_o,
  output logic [31:0] acc_low_word_o,
  output logic [31:0] dsp_control_reg_o,
  output logic op_done_o
);
  import dpda_pkg::*;

  // q15 x q15 with the single overflow case replaced
  function automatic logic [32:0] q15_mul(input logic [15:0] a, input logic [15:0] b);
    logic [31:0] prod;
    prod = 32'(signed'(a) * signed'(b));
    if (a == `DPDA_Q15_MINUS_ONE && b == `DPDA_Q15_MINUS_ONE) begin
      q15_mul = {1'b1, `DPDA_Q31_MAX};
    end else begin
      q15_mul = {1'b0, prod[30:0], 1'b0};
    end
  endfunction

  // unsigned byte product; both operands are zero-extended before the multiply
  function automatic logic [15:0] u8_mul(input logic [7:0] a, input logic [7:0] b);
    u8_mul = {8'h00, a} * {8'h00, b};
  endfunction

  // sign-extend a q31 product onto the 64-bit accumulator grid
  function automatic logic [63:0] q31_to_acc(input logic [31:0] p);
    q31_to_acc = {{32{p[31]}}, p};
  endfunction

  // one-hot mask of an accumulator, shared by the write enables and the flag update
  function automatic logic [3:0] acc_onehot(input dpda_acc_sel_t sel);
    acc_onehot = 4'h1 << sel;
  endfunction

  // above the q31 window: sign clear but guard bits not all zero
  function automatic logic over_q31(input logic [63:0] v);
    over_q31 = !v[63] && (v[`DPDA_CHK_MSB:`DPDA_CHK_LSB] != `DPDA_WORD_ZERO);
  endfunction

  // below the q31 window: sign set but guard bits not all ones
  function automatic logic under_q31(input logic [63:0] v);
    under_q31 = v[63] && (v[`DPDA_CHK_MSB:`DPDA_CHK_LSB] != `DPDA_WORD_ONES);
  endfunction

  logic [31:0] hi_reg [`DPDA_ACC_NUM];
  logic [31:0] lo_reg [`DPDA_ACC_NUM];
  logic [31:0] hi_next [`DPDA_ACC_NUM];
  logic [31:0] lo_next [`DPDA_ACC_NUM];
  logic [31:0] ctrl_reg;
  logic [31:0] ctrl_next;
  logic done_reg;
  logic done_next;
  logic [3:0] acc_wr_en;
  logic [31:0] rd_hi_reg;
  logic [31:0] rd_hi_next;
  logic [31:0] rd_lo_reg;
  logic [31:0] rd_lo_next;

  logic [15:0] a_half_hi;
  logic [15:0] a_half_lo;
  logic [15:0] b_half_hi;
  logic [15:0] b_half_lo;
  logic [7:0] a_byte_top;
  logic [7:0] a_byte_next;
  logic [7:0] b_byte_top;
  logic [7:0] b_byte_next;
  logic [32:0] prod_b;
  logic [32:0] prod_a;
  logic [15:0] ub_hi;
  logic [15:0] ub_lo;
  logic [63:0] acc_cur;
  logic [63:0] dotp;
  logic [63:0] sum;
  logic [63:0] result;
  logic sat_flag;

  always_comb begin
    a_half_hi = source_reg_a_i[`DPDA_HALF_HI_MSB:`DPDA_HALF_HI_LSB];
    a_half_lo = source_reg_a_i[`DPDA_HALF_LO_MSB:`DPDA_HALF_LO_LSB];
    b_half_hi = source_reg_b_i[`DPDA_HALF_HI_MSB:`DPDA_HALF_HI_LSB];
    b_half_lo = source_reg_b_i[`DPDA_HALF_LO_MSB:`DPDA_HALF_LO_LSB];
    a_byte_top = source_reg_a_i[`DPDA_BYTE_TOP_MSB:`DPDA_BYTE_TOP_LSB];
    a_byte_next = source_reg_a_i[`DPDA_BYTE_NEXT_MSB:`DPDA_BYTE_NEXT_LSB];
    b_byte_top = source_reg_b_i[`DPDA_BYTE_TOP_MSB:`DPDA_BYTE_TOP_LSB];
    b_byte_next = source_reg_b_i[`DPDA_BYTE_NEXT_MSB:`DPDA_BYTE_NEXT_LSB];
  end

  // all multipliers run every cycle; the op code only picks which sum is used
  always_comb begin
    prod_b = q15_mul(a_half_hi, b_half_lo);
    prod_a = q15_mul(a_half_lo, b_half_hi);
    ub_hi = u8_mul(a_byte_top, b_byte_top);
    ub_lo = u8_mul(a_byte_next, b_byte_next);
  end

  always_comb begin
    acc_cur = {hi_reg[accumulator_select_i], lo_reg[accumulator_select_i]};
    if (op_i == DPDA_OP_UBYTE_UPPER) begin
      dotp = {48'h0, ub_hi} + {48'h0, ub_lo};
    end else begin
      dotp = q31_to_acc(prod_b[31:0]) + q31_to_acc(prod_a[31:0]);
    end
    sum = acc_cur + dotp;
    result = sum;
    sat_flag = 1'b0;
    case (op_i)
      DPDA_OP_CROSS_FRAC: begin
        sat_flag = prod_b[32] | prod_a[32];
      end
      DPDA_OP_CROSS_FRAC_SAT: begin
        sat_flag = prod_b[32] | prod_a[32];
        if (over_q31(sum)) begin
          result = {`DPDA_WORD_ZERO, `DPDA_Q31_MAX};
          sat_flag = 1'b1;
        end else if (under_q31(sum)) begin
          result = {`DPDA_WORD_ONES, `DPDA_Q31_MIN};
          sat_flag = 1'b1;
        end
      end
      default: begin
        sat_flag = 1'b0;
      end
    endcase
  end

  // only the selected pair is written, high and low word on the same edge
  always_comb begin
    acc_wr_en = op_valid_i ? acc_onehot(accumulator_select_i) : 4'h0;
    for (int i = 0; i < `DPDA_ACC_NUM; i++) begin
      if (acc_wr_en[i]) begin
        hi_next[i] = result[63:32];
        lo_next[i] = result[31:0];
      end else begin
        hi_next[i] = hi_reg[i];
        lo_next[i] = lo_reg[i];
      end
    end
  end

  genvar g;
  generate
    for (g = 0; g < `DPDA_ACC_NUM; g++) begin : g_acc
      always_ff @(posedge mclk_i) begin
        if (!rstn_i) begin
          hi_reg[g] <= `DPDA_WORD_ZERO;
          lo_reg[g] <= `DPDA_WORD_ZERO;
        end else begin
          hi_reg[g] <= hi_next[g];
          lo_reg[g] <= lo_next[g];
        end
      end
    end
  endgenerate

  // flags are sticky: only reset clears them, so a later clean op cannot hide an overflow
  always_comb begin
    ctrl_next = ctrl_reg;
    if (sat_flag) begin
      ctrl_next[`DPDA_FLAG_MSB:`DPDA_FLAG_LSB] = ctrl_reg[`DPDA_FLAG_MSB:`DPDA_FLAG_LSB] | acc_wr_en;
    end
  end

  always_ff @(posedge mclk_i) begin
    if (!rstn_i) begin
      ctrl_reg <= `DPDA_CTRL_RESET;
    end else begin
      ctrl_reg <= ctrl_next;
    end
  end

  // single-cycle datapath with no exception path, so done is the request one edge later
  always_comb begin
    done_next = op_valid_i;
  end

  always_ff @(posedge mclk_i) begin
    if (!rstn_i) begin
      done_reg <= 1'b0;
    end else begin
      done_reg <= done_next;
    end
  end

  // readback takes the post-update value so a result shows in the cycle after it is taken
  always_comb begin
    rd_hi_next = hi_next[read_select_i];
    rd_lo_next = lo_next[read_select_i];
  end

  always_ff @(posedge mclk_i) begin
    if (!rstn_i) begin
      rd_hi_reg <= `DPDA_WORD_ZERO;
      rd_lo_reg <= `DPDA_WORD_ZERO;
    end else begin
      rd_hi_reg <= rd_hi_next;
      rd_lo_reg <= rd_lo_next;
    end
  end

  assign acc_high_word_o = rd_hi_reg;
  assign acc_low_word_o = rd_lo_reg;
  assign dsp_control_reg_o = ctrl_reg;
  assign op_done_o = done_reg;
endmodule
`default_nettype wire

// >>> sim/dpda_issue.sv
// issue-stage model that feeds operands to the datapath
`timescale 1ns/1ps
`default_nettype none
module dpda_issue (
  input wire logic v_i,
  input wire logic [31:0] a_i,
  input wire logic [31:0] b_i,
  output logic [31:0] a_o,
  output logic [31:0] b_o
);
  // idle lines show inverted values so nothing can rely on stale operands
  assign a_o = v_i ? a_i : ~a_i;
  assign b_o = v_i ? b_i : ~b_i;
endmodule
`default_nettype wire

// >>> sim/dpda_checker.sv
// port assertions for the dot-product datapath
`timescale 1ns/1ps
`default_nettype none
module dpda_checker (
  input wire logic mclk_i,
  input wire logic rstn_i,
  input wire logic op_valid_i,
  input wire dpda_pkg::dpda_op_t op_i,
  input wire dpda_pkg::dpda_acc_sel_t accumulator_select_i,
  input wire logic [31:0] source_reg_a_i,
  input wire logic [31:0] source_reg_b_i,
  input wire logic [31:0] dsp_control_reg_o,
  input wire logic op_done_o
);
  default clocking @(posedge mclk_i); endclocking
  default disable iff (!rstn_i);
  wire logic [3:0] f = dsp_control_reg_o[19:16];
  sequence s_m1;
    op_valid_i && !op_i[2] && source_reg_a_i[31:16] == 16'h8000 && source_reg_b_i[15:0] == 16'h8000;
  endsequence
  property p_done; op_valid_i |=> op_done_o; endproperty
  a_done: assert property (p_done) else $error("no done pulse");
  property p_idle; !op_valid_i |=> !op_done_o && $stable(dsp_control_reg_o); endproperty
  a_idle: assert property (p_idle) else $error("idle change");
  property p_rsv; {dsp_control_reg_o[31:20], dsp_control_reg_o[15:0]} == 28'h0; endproperty
  a_rsv: assert property (p_rsv) else $error("stray control bit");
  property p_ub; op_valid_i && op_i[2] |=> $stable(f); endproperty
  a_ub: assert property (p_ub) else $error("byte op moved flag");
  property p_m1; s_m1 |=> f[$past(accumulator_select_i)]; endproperty
  a_m1: assert property (p_m1) else $error("no flag on first product");
  sequence s_m2;
    op_valid_i && !op_i[2] && source_reg_a_i == 32'h80008000 && source_reg_b_i == 32'h80008000;
  endsequence
  property p_m2; s_m2 |=> f == ($past(f) | (4'h1 << $past(accumulator_select_i))); endproperty
  a_m2: assert property (p_m2) else $error("no flag on products");
  property p_one; op_valid_i |=> (f & ~$past(f) & ~(4'h1 << $past(accumulator_select_i))) == 4'h0; endproperty
  a_one: assert property (p_one) else $error("wrong flag bit");
  property p_keep; 1 |=> (f & $past(f)) == $past(f); endproperty
  a_keep: assert property (p_keep) else $error("flag cleared");
endmodule
bind dpda_datapath dpda_checker u_chk (.mclk_i, .rstn_i, .op_valid_i, .op_i, .accumulator_select_i,
  .source_reg_a_i, .source_reg_b_i, .dsp_control_reg_o, .op_done_o);
`default_nettype wire

// >>> sim/dpda_datapath_bench.sv
// self-checking bench for the dot-product datapath
`timescale 1ns/1ps
`default_nettype none
module dpda_datapath_bench;
  import dpda_pkg::*;
  logic mclk_i = 1'b0, rstn_i = 1'b0, v = 1'b0, op_done_o;
  logic [31:0] a = 32'h0, b = 32'h0, sa, sb, hi, lo, ctl, w, seed = 32'h86A3F63A;
  logic [63:0] acc [4] = '{default: 64'h0};
  logic [95:0] eq [$];
  logic [3:0] fl = 4'h0;
  dpda_op_t op_i = DPDA_OP_CROSS_FRAC;
  dpda_op_t ops [4] = '{DPDA_OP_CROSS_FRAC, DPDA_OP_CROSS_FRAC_SAT, DPDA_OP_UBYTE_UPPER, DPDA_OP_CROSS_FRAC_SAT};
  dpda_acc_sel_t s = 2'h0;
  int fail_count = 0, n_compared = 0;
  always #20 mclk_i = ~mclk_i;
  dpda_issue u_iss (.v_i(v), .a_i(a), .b_i(b), .a_o(sa), .b_o(sb));
  dpda_datapath dut (.mclk_i, .rstn_i, .op_valid_i(v), .op_i, .accumulator_select_i(s),
    .source_reg_a_i(sa), .source_reg_b_i(sb), .read_select_i(s), .acc_high_word_o(hi),
    .acc_low_word_o(lo), .dsp_control_reg_o(ctl), .op_done_o);
  function logic [31:0] xs();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction
  function automatic logic [31:0] q(logic [15:0] x, logic [15:0] y);
    return (x == 16'h8000 && y == 16'h8000) ? 32'h7FFFFFFF : 32'($signed(x) * $signed(y)) << 1;
  endfunction
  task chk(logic [95:0] g, logic [95:0] x);
    n_compared++;
    if (g !== x) $display("mismatch at %0t got %h exp %h", $time, g, x);
    fail_count += int'(g !== x);
  endtask
  task test_done();
    $display("compared %0d failed %0d", n_compared, fail_count);
    if (fail_count == 0 && n_compared > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask
  task issue(dpda_op_t o, dpda_acc_sel_t k, logic [31:0] x, logic [31:0] y);
    logic signed [63:0] p, r, t;
    @(negedge mclk_i);
    op_i = o;
    {v, s, a, b} = {1'b1, k, x, y};
    p = $signed(q(x[31:16], y[15:0]));
    r = $signed(q(x[15:0], y[31:16]));
    t = o[2] ? acc[k] + x[31:24] * y[31:24] + x[23:16] * y[23:16] : acc[k] + p + r;
    if (!o[2]) fl[k] |= p == 32'h7FFFFFFF || r == 32'h7FFFFFFF;
    if (o[1] && t[62:31] != {32{t[63]}}) begin
      t = t[63] ? {32'hFFFFFFFF, 32'h80000000} : {32'h0, 32'h7FFFFFFF};
      fl[k] = 1'b1;
    end
    acc[k] = t;
    eq.push_back({t, 12'h0, fl, 16'h0});
  endtask
  // readback follows the op's selector, so each done shows the updated pair
  always @(negedge mclk_i) if (op_done_o === 1'b1) chk({hi, lo, ctl}, eq.size() ? eq.pop_front() : 96'h0);
  initial begin
    repeat (4) @(negedge mclk_i);
    rstn_i = 1'b1;
    @(negedge mclk_i) chk({hi, lo, ctl}, 96'h0);
    repeat (400) begin
      w = xs();
      if (w[0]) issue(ops[w[2:1]], w[4:3], &w[6:5] ? 32'h80008000 : xs(), &w[6:5] ? 32'h80008000 : xs());
      else @(negedge mclk_i) v = 1'b0;
    end
    @(negedge mclk_i) v = 1'b0;
    repeat (9) if (eq.size() > 0) @(negedge mclk_i);
    if (eq.size() > 0) fail_count++;
    test_done();
  end
endmodule
`default_nettype wire
